//--- rtl/mwj_top.sv
`timescale 1ns/100ps
// How it works
// - pattern entry is four mask words, then crc/offset
// - pattern offset is eight bits, zero to 255
// - watchdog releases after 24 or 48 bit-times
// - watchdog expires past 2560 bytes unless disabled
// - jabber cutoff 2.6/26 ms or 2560 byte-times
// - lockout after jabber lasts 42 or 420 ms
// - no-lockout mode re-enables transmit at once
// - jabber off disables the cutoff entirely
// - tx early flag set on fifo fill when enabled, w1c
// - rx early flag set on first descriptor when enabled, w1c
// - transceiver flag latches or of bits 6..0, w1c
// - deferred flag is latched, w1c
// - pause flag set on pause frame when enabled
// - bus error type encodes parity, master, target
// - bus error type raises no interrupt
module mwj_top #(
  parameter int JABBER_100_CYC  = mwj_pkg::JABBER_100_CYC,
  parameter int JABBER_10_CYC   = mwj_pkg::JABBER_10_CYC,
  parameter int LOCKOUT_100_CYC = mwj_pkg::LOCKOUT_100_CYC,
  parameter int LOCKOUT_10_CYC  = mwj_pkg::LOCKOUT_10_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        speed_100,
  input  wire logic        rx_carrier,
  input  wire logic        rx_byte_en,
  input  wire logic        rx_bit_en,
  input  wire logic        tx_active,
  input  wire logic        tx_byte_en,
  input  wire logic        tx_fifo_fill_evt,
  input  wire logic        rx_first_desc_evt,
  input  wire logic        tx_defer_evt,
  input  wire logic        pause_frame_evt,
  input  wire logic        pause_fn_en,
  input  wire logic [6:0]  transceiver_irq_reg,
  input  wire logic        fatal_bus_error_flag,
  input  wire logic [2:0]  bus_err_code,
  input  wire logic [4:0]  wake_rd_idx,
  output logic [31:0]      wake_rd_word,
  output logic [39:0]      wake_offsets,
  output logic [79:0]      wake_crcs,
  output logic             rx_watchdog_trip,
  output logic             tx_jabber_block,
  output logic             tx_jabber_expired
);

  // apb decode
  wire       setup_rd   = psel && !penable && !pwrite;
  wire       wr_go      = psel && penable && pwrite;
  wire       hit_wake   = (paddr == mwj_pkg::WAKE_PATTERN_DATA_ADDR);
  wire       hit_tctl   = (paddr == mwj_pkg::TIMER_CTRL_ADDR);
  wire       hit_stat   = (paddr == mwj_pkg::SEC_STATUS_ADDR);
  wire       hit_ien    = (paddr == mwj_pkg::SEC_IRQ_ENABLE_ADDR);
  wire       hit_wctl   = (paddr == mwj_pkg::WAKE_LOAD_CTRL_ADDR);
  wire       hit_any    = hit_wake | hit_tctl | hit_stat | hit_ien | hit_wctl;
  wire       wr_wake    = wr_go && hit_wake;
  wire       wr_tctl    = wr_go && hit_tctl;
  wire       wr_stat    = wr_go && hit_stat;
  wire       wr_ien     = wr_go && hit_ien;
  wire       wr_wctl    = wr_go && hit_wctl;

  // zero wait states: read data is latched in the setup cycle
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit_any;

  // control registers
  logic [5:0] tctl_q;
  logic [4:0] ien_q;

  wire rel_sel    = tctl_q[mwj_pkg::RX_WDOG_RELEASE_SEL_BIT];
  wire wdog_off   = tctl_q[mwj_pkg::RX_WDOG_OFF_BIT];
  wire jab_sel    = tctl_q[mwj_pkg::JABBER_CUTOFF_SEL_BIT];
  wire no_lockout = tctl_q[mwj_pkg::NO_JABBER_LOCKOUT_BIT];
  wire jab_off    = tctl_q[mwj_pkg::JABBER_OFF_BIT];
  wire tx_early_irq_en = ien_q[4];
  wire rx_early_irq_en = ien_q[3];

  // reserved bits 3 and 31..6 are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctl_q <= mwj_pkg::TIMER_CTRL_RESET;
      ien_q  <= mwj_pkg::IRQ_ENABLE_RESET;
    end else begin
      if (wr_tctl) tctl_q <= pwdata[5:0] & 6'h37;
      if (wr_ien)  ien_q  <= {pwdata[31:28], pwdata[26]};
    end
  end

  // wake image
  logic [31:0] wake_mem_q [mwj_pkg::WAKE_WORDS];
  logic [4:0]  wake_ptr_q;
  logic        wake_loaded_q;

  wire wake_restart = wr_wctl && pwdata[mwj_pkg::WAKE_PTR_RESTART_BIT];
  wire wake_at_last = (wake_ptr_q == mwj_pkg::WAKE_LAST_IDX);

  // each write lands at the pointer, which steps through the image in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ptr_q    <= 5'h00;
      wake_loaded_q <= 1'b0;
    end else if (wake_restart) begin
      wake_ptr_q    <= 5'h00;
      wake_loaded_q <= 1'b0;
    end else if (wr_wake) begin
      wake_ptr_q    <= wake_at_last ? 5'h00 : wake_ptr_q + 5'h01;
      if (wake_at_last) wake_loaded_q <= 1'b1;
    end
  end

  // storage carries no reset; the image is only valid once loaded
  always_ff @(posedge pclk) begin
    if (wr_wake) wake_mem_q[wake_ptr_q] <= pwdata;
  end

  function automatic int pat_word(input int pat, input int word);
    return pat * mwj_pkg::WAKE_WORDS_PER + word;
  endfunction

  // per-pattern fields come from the fifth word of each entry
  genvar gp;
  generate
    for (gp = 0; gp < mwj_pkg::WAKE_PATTERNS; gp++) begin : g_pat
      assign wake_offsets[gp*8 +: 8] =
        wake_mem_q[pat_word(gp, mwj_pkg::WAKE_CRC_WORD)][mwj_pkg::WAKE_OFFSET_LSB +: mwj_pkg::WAKE_OFFSET_WIDTH];
      assign wake_crcs[gp*16 +: 16] =
        wake_mem_q[pat_word(gp, mwj_pkg::WAKE_CRC_WORD)][mwj_pkg::WAKE_CRC_LSB +: 16];
    end
  endgenerate

  wire idx_ok = (wake_rd_idx <= mwj_pkg::WAKE_LAST_IDX);

  // filter port: words 0..3 of an entry are mask bits 31:0 up to 127:96
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_rd_word <= 32'h0000_0000;
    end else begin
      wake_rd_word <= idx_ok ? wake_mem_q[wake_rd_idx] : 32'h0000_0000;
    end
  end

  // secondary status
  logic tx_early_q;
  logic rx_early_q;
  logic xcvr_q;
  logic defer_q;
  logic pause_q;
  logic [2:0] bus_err_q;

  wire xcvr_any  = |transceiver_irq_reg;
  wire clr_tx_e  = wr_stat && pwdata[mwj_pkg::TX_EARLY_BIT];
  wire clr_rx_e  = wr_stat && pwdata[mwj_pkg::RX_EARLY_BIT];
  wire clr_xcvr  = wr_stat && pwdata[mwj_pkg::XCVR_EVENT_BIT];
  wire clr_defer = wr_stat && pwdata[mwj_pkg::TX_DEFER_BIT];
  wire clr_pause = wr_stat && pwdata[mwj_pkg::PAUSE_RX_BIT];
  wire set_tx_e  = tx_fifo_fill_evt && tx_early_irq_en;
  wire set_rx_e  = rx_first_desc_evt && rx_early_irq_en;
  wire set_pause = pause_frame_evt && pause_fn_en;

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_early_q <= 1'b0;
      rx_early_q <= 1'b0;
      xcvr_q     <= mwj_pkg::XCVR_EVENT_RESET;
      defer_q    <= 1'b0;
      pause_q    <= 1'b0;
    end else begin
      tx_early_q <= set_tx_e  | (tx_early_q & ~clr_tx_e);
      rx_early_q <= set_rx_e  | (rx_early_q & ~clr_rx_e);
      xcvr_q     <= xcvr_any  | (xcvr_q & ~clr_xcvr);
      defer_q    <= tx_defer_evt | (defer_q & ~clr_defer);
      pause_q    <= set_pause | (pause_q & ~clr_pause);
    end
  end

  // error code is held from the moment the fatal flag is seen; no event is made
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_err_q <= mwj_pkg::BUS_ERR_RESET;
    end else if (fatal_bus_error_flag) begin
      bus_err_q <= bus_err_code;
    end
  end

  wire [31:0] stat_word = {tx_early_q, rx_early_q, xcvr_q, defer_q, 1'b0, pause_q,
                           bus_err_q, 23'h000000};
  wire [31:0] ien_word  = {ien_q[4:1], 1'b0, ien_q[0], 26'h0000000};
  wire [31:0] wctl_word = {23'h000000, wake_loaded_q, 3'h0, wake_ptr_q};
  wire [31:0] wake_word = wake_mem_q[wake_ptr_q];
  wire [31:0] rd_mux    = hit_wake ? wake_word :
                          hit_tctl ? {26'h0000000, tctl_q} :
                          hit_stat ? stat_word :
                          hit_ien  ? ien_word :
                          hit_wctl ? wctl_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  // rx watchdog
  mwj_pkg::mwj_wdog_e wd_q;
  mwj_pkg::mwj_wdog_e wd_d;
  logic               wd_done;

  // idle already counts the first byte, and the release count starts on the first cycle without carrier
  wire        wd_bytes = (wd_q == mwj_pkg::WD_IDLE) || (wd_q == mwj_pkg::WD_COUNT);
  wire        wd_clr   = ((wd_q == mwj_pkg::WD_IDLE) && !rx_carrier) || (!wd_bytes && rx_carrier) ||
                         ((wd_q == mwj_pkg::WD_COUNT) && (wd_d != mwj_pkg::WD_COUNT));
  wire        wd_tick  = wd_bytes ? rx_byte_en : rx_bit_en;
  wire [24:0] wd_rel   = rel_sel ? 25'(mwj_pkg::RX_RELEASE_LONG) : 25'(mwj_pkg::RX_RELEASE_SHORT);
  wire [24:0] wd_limit = wd_bytes ? 25'(mwj_pkg::RX_WDOG_MAX_BYTES + 1) : wd_rel;

  mwj_timer #(.W(mwj_pkg::TIMER_WIDTH)) u_wd_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (wd_clr),
    .tick    (wd_tick),
    .limit   (wd_limit),
    .done    (wd_done)
  );

  // the release count restarts if carrier returns during it
  always_comb begin
    wd_d = wd_q;
    unique case (wd_q)
      mwj_pkg::WD_IDLE:    if (rx_carrier) wd_d = mwj_pkg::WD_COUNT;
      mwj_pkg::WD_COUNT:   if (wd_done) wd_d = mwj_pkg::WD_EXPIRED;
                           else if (!rx_carrier) wd_d = mwj_pkg::WD_IDLE;
      mwj_pkg::WD_EXPIRED: if (!rx_carrier) wd_d = mwj_pkg::WD_RELEASE;
      mwj_pkg::WD_RELEASE: if (rx_carrier) wd_d = mwj_pkg::WD_EXPIRED;
                           else if (wd_done) wd_d = mwj_pkg::WD_IDLE;
    endcase
    if (wdog_off) wd_d = mwj_pkg::WD_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_q <= mwj_pkg::WD_IDLE;
    else          wd_q <= wd_d;
  end

  assign rx_watchdog_trip = (wd_q == mwj_pkg::WD_EXPIRED) || (wd_q == mwj_pkg::WD_RELEASE);

  // tx jabber
  mwj_pkg::mwj_jab_e jb_q;
  mwj_pkg::mwj_jab_e jb_d;
  logic              jb_done;
  logic              jb_exp_q;

  wire [24:0] jb_cut  = jab_sel   ? 25'(mwj_pkg::JABBER_BYTES) :
                        speed_100 ? 25'(JABBER_100_CYC) : 25'(JABBER_10_CYC);
  wire [24:0] jb_lock = speed_100 ? 25'(LOCKOUT_100_CYC) : 25'(LOCKOUT_10_CYC);
  wire [24:0] jb_limit = (jb_q == mwj_pkg::JB_LOCK) ? jb_lock : jb_cut;
  // idle counts the first cycle of a frame, so no byte strobe is lost at the start
  wire        jb_tick  = (jb_q != mwj_pkg::JB_LOCK && jab_sel) ? tx_byte_en : 1'b1;
  wire        jb_clr   = ((jb_q == mwj_pkg::JB_IDLE) && !tx_active) ||
                         ((jb_q != mwj_pkg::JB_IDLE) && (jb_d != jb_q));
  wire        jb_fire  = (jb_q == mwj_pkg::JB_RUN) && tx_active && jb_done;

  mwj_timer #(.W(mwj_pkg::TIMER_WIDTH)) u_jb_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (jb_clr),
    .tick    (jb_tick),
    .limit   (jb_limit),
    .done    (jb_done)
  );

  // with lockout skipped the frame's own count simply starts over
  always_comb begin
    jb_d = jb_q;
    unique case (jb_q)
      mwj_pkg::JB_IDLE: if (tx_active) jb_d = mwj_pkg::JB_RUN;
      mwj_pkg::JB_RUN:  if (!tx_active) jb_d = mwj_pkg::JB_IDLE;
                        else if (jb_done) jb_d = no_lockout ? mwj_pkg::JB_IDLE : mwj_pkg::JB_LOCK;
      mwj_pkg::JB_LOCK: if (jb_done) jb_d = mwj_pkg::JB_IDLE;
      default:          jb_d = mwj_pkg::JB_IDLE;
    endcase
    if (jab_off) jb_d = mwj_pkg::JB_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jb_q     <= mwj_pkg::JB_IDLE;
      jb_exp_q <= 1'b0;
    end else begin
      jb_q     <= jb_d;
      jb_exp_q <= jb_fire && !jab_off;
    end
  end

  assign tx_jabber_block   = (jb_q == mwj_pkg::JB_LOCK);
  assign tx_jabber_expired = jb_exp_q;

endmodule // mwj_top

//--- rtl/mwj_pkg.sv
package mwj_pkg;

  // register byte addresses
  localparam logic [7:0] WAKE_PATTERN_DATA_ADDR = 8'h70;
  localparam logic [7:0] TIMER_CTRL_ADDR        = 8'h78;
  localparam logic [7:0] SEC_STATUS_ADDR        = 8'h80;
  localparam logic [7:0] SEC_IRQ_ENABLE_ADDR    = 8'h84;
  localparam logic [7:0] WAKE_LOAD_CTRL_ADDR    = 8'h8c;

  // wake-up filter image layout
  localparam int WAKE_WORDS        = 25;
  localparam int WAKE_PATTERNS     = 5;
  localparam int WAKE_WORDS_PER    = 5;
  localparam int WAKE_CRC_WORD     = 4;
  localparam int WAKE_CRC_LSB      = 16;
  localparam int WAKE_OFFSET_LSB   = 0;
  localparam int WAKE_OFFSET_WIDTH = 8;
  localparam logic [4:0] WAKE_LAST_IDX = 5'h18;

  // timer control fields
  localparam int RX_WDOG_RELEASE_SEL_BIT = 5;
  localparam int RX_WDOG_OFF_BIT         = 4;
  localparam int JABBER_CUTOFF_SEL_BIT   = 2;
  localparam int NO_JABBER_LOCKOUT_BIT   = 1;
  localparam int JABBER_OFF_BIT          = 0;
  localparam logic [5:0] TIMER_CTRL_RESET = 6'h00;

  // secondary status / enable fields
  localparam int TX_EARLY_BIT   = 31;
  localparam int RX_EARLY_BIT   = 30;
  localparam int XCVR_EVENT_BIT = 29;
  localparam int TX_DEFER_BIT   = 28;
  localparam int PAUSE_RX_BIT   = 26;
  localparam int BUS_ERR_LSB    = 23;
  localparam logic       XCVR_EVENT_RESET = 1'b1;
  localparam logic [2:0] BUS_ERR_RESET    = 3'h0;
  localparam logic [2:0] BUS_ERR_PARITY   = 3'h0;
  localparam logic [2:0] BUS_ERR_MASTER   = 3'h1;
  localparam logic [2:0] BUS_ERR_TARGET   = 3'h2;
  localparam logic [4:0] IRQ_ENABLE_RESET = 5'h00;

  // wake load control fields
  localparam int WAKE_PTR_RESTART_BIT = 0;
  localparam int WAKE_LOADED_BIT      = 8;

  // timing: counts in bytes / bits, times in ns
  localparam int TIMER_WIDTH        = 25;
  localparam int CLK_PERIOD_NS      = 25;
  localparam int RX_WDOG_MAX_BYTES  = 2560;
  localparam int RX_RELEASE_SHORT   = 24;
  localparam int RX_RELEASE_LONG    = 48;
  localparam int JABBER_BYTES       = 2560;
  localparam int JABBER_100_NS      = 2_600_000;
  localparam int JABBER_10_NS       = 26_000_000;
  localparam int LOCKOUT_100_NS     = 42_000_000;
  localparam int LOCKOUT_10_NS      = 420_000_000;
  localparam int JABBER_100_CYC     = JABBER_100_NS / CLK_PERIOD_NS;
  localparam int JABBER_10_CYC      = JABBER_10_NS / CLK_PERIOD_NS;
  localparam int LOCKOUT_100_CYC    = LOCKOUT_100_NS / CLK_PERIOD_NS;
  localparam int LOCKOUT_10_CYC     = LOCKOUT_10_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_COUNT   = 2'b01,
    WD_EXPIRED = 2'b11,
    WD_RELEASE = 2'b10
  } mwj_wdog_e;

  typedef enum logic [1:0] {
    JB_IDLE = 2'b00,
    JB_RUN  = 2'b01,
    JB_LOCK = 2'b11
  } mwj_jab_e;

endpackage

//--- rtl/mwj_timer.sv
`timescale 1ns/100ps
// saturating tick counter; done once the count reaches limit
module mwj_timer #(
  parameter int W = 25
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_q;

  assign done = (cnt_q >= limit);

  // clear has priority so a restart never sees a stale count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (tick && !done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // mwj_timer

//--- bench/mwj_asserts.sv
`timescale 1ns/100ps
// register bus, watchdog and jabber relations at the mwj_top ports
module mwj_asserts #(
  parameter int JABBER_100_CYC  = mwj_pkg::JABBER_100_CYC,
  parameter int JABBER_10_CYC   = mwj_pkg::JABBER_10_CYC,
  parameter int LOCKOUT_100_CYC = mwj_pkg::LOCKOUT_100_CYC,
  parameter int LOCKOUT_10_CYC  = mwj_pkg::LOCKOUT_10_CYC
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       speed_100,
  input wire logic       rx_carrier,
  input wire logic       rx_byte_en,
  input wire logic       rx_bit_en,
  input wire logic       tx_active,
  input wire logic       rx_watchdog_trip,
  input wire logic       tx_jabber_block,
  input wire logic       tx_jabber_expired
);
  logic [31:0] blk_q;
  logic [31:0] act_q;
  logic [31:0] rxb_q;
  logic [31:0] bit_q;

  // run lengths; byte count holds after carrier drops so the trip edge still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_q <= 32'h0;
      act_q <= 32'h0;
      rxb_q <= 32'h0;
      bit_q <= 32'h0;
    end else begin
      blk_q <= tx_jabber_block ? blk_q + 32'h1 : 32'h0;
      act_q <= tx_active ? act_q + 32'h1 : 32'h0;
      rxb_q <= $rose(rx_carrier) ? 32'(rx_byte_en) : rxb_q + 32'(rx_byte_en);
      bit_q <= rx_carrier ? 32'h0 : bit_q + 32'(rx_bit_en);
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_exp_once;
    tx_jabber_expired ##1 !tx_jabber_expired;
  endsequence

  a_zero_wait: assert property (s_acc |-> pready) else $error("pready late");
  a_unmapped_err: assert property (s_acc |-> pslverr == !(paddr inside {8'h70, 8'h78, 8'h80, 8'h84, 8'h8c}))
    else $error("pslverr wrong");
  a_exp_pulse: assert property (tx_jabber_expired |-> s_exp_once) else $error("expiry not one cycle");
  a_jab_run: assert property ($rose(tx_jabber_expired) |->
    act_q >= (speed_100 ? JABBER_100_CYC : JABBER_10_CYC)) else $error("jabber cut too early");
  a_lock_cause: assert property ($rose(tx_jabber_block) |-> tx_jabber_expired || $past(tx_jabber_expired))
    else $error("lockout without expiry");
  a_lock_len: assert property ($fell(tx_jabber_block) |->
    blk_q - (speed_100 ? LOCKOUT_100_CYC : LOCKOUT_10_CYC) <= 32'h1) else $error("lockout length");
  a_trip_len: assert property ($rose(rx_watchdog_trip) |->
    rxb_q == 32'(mwj_pkg::RX_WDOG_MAX_BYTES) + 32'h1) else $error("watchdog trip count");
  a_trip_release: assert property ($fell(rx_watchdog_trip) |->
    bit_q == 32'(mwj_pkg::RX_RELEASE_SHORT) || bit_q == 32'(mwj_pkg::RX_RELEASE_LONG)) else $error("release");
endmodule // mwj_asserts

bind mwj_top mwj_asserts #(
  .JABBER_100_CYC(JABBER_100_CYC), .JABBER_10_CYC(JABBER_10_CYC),
  .LOCKOUT_100_CYC(LOCKOUT_100_CYC), .LOCKOUT_10_CYC(LOCKOUT_10_CYC)
) u_asserts (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .speed_100, .rx_carrier,
  .rx_byte_en, .rx_bit_en, .tx_active, .rx_watchdog_trip, .tx_jabber_block, .tx_jabber_expired
);

//--- bench/mwj_line.sv
`timescale 1ns/100ps
// line side: frames of len bytes, a byte strobe every fourth cycle
module mwj_line (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rx_go,
  input  wire logic        tx_go,
  input  wire logic [15:0] len,
  output logic             rx_carrier,
  output logic             rx_byte_en,
  output logic             rx_bit_en,
  output logic             tx_active,
  output logic             tx_byte_en,
  output logic             busy
);
  logic [15:0] rxn_q;
  logic [15:0] txn_q;
  logic [1:0]  ph_q;

  // bit tick runs free; spacing keeps release counts easy to see
  assign rx_carrier = rxn_q != 16'h0;
  assign tx_active  = txn_q != 16'h0;
  assign rx_bit_en  = ph_q == 2'h3;
  assign rx_byte_en = rx_carrier && ph_q == 2'h1;
  assign tx_byte_en = tx_active && ph_q == 2'h1;
  assign busy       = rx_carrier || tx_active;

  // remaining bytes of each frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxn_q <= 16'h0;
      txn_q <= 16'h0;
      ph_q  <= 2'h0;
    end else begin
      ph_q  <= ph_q + 2'h1;
      rxn_q <= rx_go ? len : rxn_q - 16'(rx_byte_en);
      txn_q <= tx_go ? len : txn_q - 16'(tx_byte_en);
    end
  end
endmodule // mwj_line

//--- bench/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tb;
  localparam logic [7:0] TC = mwj_pkg::TIMER_CTRL_ADDR;
  localparam logic [7:0] ST = mwj_pkg::SEC_STATUS_ADDR;
  localparam logic [7:0] IE = mwj_pkg::SEC_IRQ_ENABLE_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, speed_100, car, rxb, rxbit, txa, txb;
  logic        pause_fn_en, fbe, rgo, tgo, busy, trip, blk, expd, tseen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd, wrd;
  logic [31:0] w [25];
  logic [32:0] q [$];
  logic [32:0] nt;
  logic [6:0]  irq;
  logic [3:0]  ev;
  logic [2:0]  bec;
  logic [4:0]  idx;
  logic [15:0] len;
  logic [39:0] offs;
  logic [79:0] crcs;
  int          checks, err_total, exp_n, blk_n, tb_n, ac_n, exp_b, exp_c;

  mwj_top #(.JABBER_100_CYC(40), .JABBER_10_CYC(60), .LOCKOUT_100_CYC(80), .LOCKOUT_10_CYC(100)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .speed_100,
    .rx_carrier(car), .rx_byte_en(rxb), .rx_bit_en(rxbit), .tx_active(txa), .tx_byte_en(txb),
    .tx_fifo_fill_evt(ev[0]), .rx_first_desc_evt(ev[1]), .tx_defer_evt(ev[2]), .pause_frame_evt(ev[3]),
    .pause_fn_en, .transceiver_irq_reg(irq), .fatal_bus_error_flag(fbe), .bus_err_code(bec),
    .wake_rd_idx(idx), .wake_rd_word(wrd), .wake_offsets(offs), .wake_crcs(crcs),
    .rx_watchdog_trip(trip), .tx_jabber_block(blk), .tx_jabber_expired(expd));
  mwj_line LINE (.pclk, .presetn, .rx_go(rgo), .tx_go(tgo), .len, .rx_carrier(car), .rx_byte_en(rxb),
    .rx_bit_en(rxbit), .tx_active(txa), .tx_byte_en(txb), .busy);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; a read leaves its expected word and error bit as a note
  task automatic ap(input logic w1, input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
    if (!w1) q.push_back({er, d});
    psel <= 1'b1;
    pwrite <= w1;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pul(input logic [3:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
  endtask

  // one frame on the line with the given timer control; waits out release and lockout
  task automatic frm(input logic tx, input logic [15:0] n, input logic [31:0] c);
    ap(1'b1, TC, c);
    tseen = 1'b0;
    exp_n = 0;
    blk_n = 0;
    tb_n = 0;
    ac_n = 0;
    exp_b = 0;
    exp_c = 0;
    len <= n;
    rgo <= !tx;
    tgo <= tx;
    @(posedge pclk);
    rgo <= 1'b0;
    tgo <= 1'b0;
    do @(posedge pclk); while (busy);
    repeat (300) @(posedge pclk);
  endtask

  // read notes are settled at the access edge; frame counters run alongside
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      `CHK("prdata", nt[31:0], prdata)
      `CHK("pslverr", nt[32], pslverr)
    end
    if (trip) tseen = 1'b1;
    if (blk) blk_n++;
    if (txb) tb_n++;
    if (txa) ac_n++;
    if (expd && exp_n == 0) exp_b = tb_n;
    if (expd && exp_n == 0) exp_c = ac_n;
    if (expd) exp_n++;
  end

  // about 80k cycles; the sequence needs roughly 55k
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, irq, ev, bec, idx, len} = '0;
    {speed_100, pause_fn_en, fbe, rgo, tgo, presetn} = '0;
    rnd = 32'h8fbf;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ap(1'b0, TC, '0);
    ap(1'b0, ST, 32'h2000_0000);
    ap(1'b0, IE, '0);
    ap(1'b0, 8'h90, '0, 1'b1);
    ap(1'b1, TC, 32'h37);
    ap(1'b0, TC, 32'h37);
    ap(1'b1, ST, 32'h2000_0000);
    ap(1'b0, ST, '0);
    for (int k = 0; k < 7; k++) begin
      irq <= rnd[6:0] | 7'(1 << k);
      rnd = nxt(rnd);
      @(posedge pclk);
      irq <= 7'h0;
      @(posedge pclk);
      ap(1'b0, ST, 32'h2000_0000);
      ap(1'b1, ST, 32'h2000_0000);
    end
    pul(4'hf);
    ap(1'b0, ST, 32'h1000_0000);
    ap(1'b1, ST, 32'h1000_0000);
    ap(1'b1, IE, 32'hf400_0000);
    ap(1'b0, IE, 32'hf400_0000);
    pause_fn_en <= 1'b1;
    pul(4'hf);
    ap(1'b0, ST, 32'hd400_0000);
    ap(1'b1, ST, 32'h8000_0000);
    ap(1'b0, ST, 32'h5400_0000);
    ap(1'b1, ST, 32'h5400_0000);
    ap(1'b0, ST, '0);
    for (int k = 0; k < 3; k++) begin
      bec <= 3'(k);
      fbe <= 1'b1;
      @(posedge pclk);
      fbe <= 1'b0;
      bec <= rnd[2:0];
      rnd = nxt(rnd);
      @(posedge pclk);
      ap(1'b0, ST, 32'(k) << 23);
    end
    ap(1'b1, 8'h8c, 32'h1);
    for (int i = 0; i < 25; i++) begin
      w[i] = rnd;
      if (i == 4) w[i][7:0] = 8'hff;
      rnd = nxt(rnd);
      ap(1'b1, 8'h70, w[i]);
    end
    ap(1'b0, 8'h8c, 32'h100);
    for (int i = 0; i < 26; i++) begin
      idx <= 5'(i);
      repeat (2) @(posedge pclk);
      `CHK("wake word", i < 25 ? w[i] : 32'h0, wrd)
    end
    for (int p = 0; p < 5; p++) begin
      `CHK("offset", w[p * 5 + 4][7:0], offs[p * 8 +: 8])
      `CHK("crc", w[p * 5 + 4][31:16], crcs[p * 16 +: 16])
    end
    // long, long release, exactly at the limit, watchdog off
    for (int i = 0; i < 4; i++) begin
      frm(1'b0, i == 2 ? 16'ha00 : 16'ha01, i == 1 ? 32'h20 : i == 3 ? 32'h10 : 32'h0);
      `CHK("trip seen", 1'(i < 2), tseen)
      `CHK("trip low", 1'b0, trip)
    end
    speed_100 <= 1'b1;
    frm(1'b1, 16'h1e, 32'h0);
    `CHK("cut 100", 1'b1, exp_c inside {[40:44]})
    `CHK("lockout", 1'b1, blk_n != 0)
    speed_100 <= 1'b0;
    frm(1'b1, 16'h28, 32'h0);
    `CHK("cut 10", 1'b1, exp_c inside {[60:64]})
    `CHK("lockout", 1'b1, blk_n != 0)
    frm(1'b1, 16'h1e, 32'h2);
    `CHK("expired", 1'b1, exp_n != 0)
    `CHK("no lockout", 0, blk_n)
    frm(1'b1, 16'h1e, 32'h1);
    `CHK("jabber off", 0, exp_n)
    frm(1'b1, 16'ha28, 32'h6);
    `CHK("byte cutoff", 2560, exp_b)
    end_of_test();
  end
endmodule // tb
